/* File: awcr_regs.v */
// Overview of operation
// - channel-1 sum low byte, read-only at 0Ah
// - channel-1 sum high byte, read-only at 0Bh
// - results cleared by reset, general call, sequence start
// - accumulation count in bits 3-0 at 02h
// - status upper nibble reads zero, ignores writes
// - bit 0 of 37h switches window comparator
// - bit 1 of 34h gates channel-1 alerts
// - bit 0 of 34h gates channel-0 alerts
// - high-threshold upper nibble in 39h bits 3-0
// - high-threshold low byte in 38h
// - low-threshold upper nibble in 3Bh bits 3-0
// - low-threshold low byte in 3Ah
// - comparator enable bits 7-1 read zero
// - accumulator runs only on enable code 1111b
`timescale 1ns/1ps
`default_nettype none
`include "awcr_defines.vh"

module awcr_regs (
    // clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // register access from the serial interface engine
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    output wire reg_hit_out,
    // clearing events
    input wire general_call_reset_in,
    input wire device_reset_in,
    input wire sequence_go_in,
    // conversion results from the converter
    input wire conv_done_in,
    input wire conv_chan_in,
    input wire [11:0] conv_data_in,
    // channel-1 comparator events from outside this slice
    input wire chan1_above_in,
    input wire chan1_below_in,
    // controls to the datapaths
    output wire summing_active_out,
    output wire window_compare_on_out,
    output wire chan0_alert_on_out,
    output wire chan1_alert_on_out,
    output wire [11:0] chan0_upper_limit_out,
    output wire [11:0] chan0_lower_limit_out,
    // accumulator results
    output wire [15:0] chan1_sum_out,
    output wire [3:0] accumulations_done_out,
    // alerts
    output reg chan0_alert_out,
    output reg chan1_alert_out
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    // used by the hit flag only; the write strobes decode through wr_hit
    function is_writable;
        input [7:0] addr;
        begin
            case (addr)
                `AWCR_ADDR_SUMMING_EN: is_writable = 1'b1;
                `AWCR_ADDR_ALERT_EN: is_writable = 1'b1;
                `AWCR_ADDR_WINDOW_EN: is_writable = 1'b1;
                `AWCR_ADDR_UPPER_LOW: is_writable = 1'b1;
                `AWCR_ADDR_UPPER_HIGH: is_writable = 1'b1;
                `AWCR_ADDR_LOWER_LOW: is_writable = 1'b1;
                `AWCR_ADDR_LOWER_HIGH: is_writable = 1'b1;
                default: is_writable = 1'b0;
            endcase
        end
    endfunction

    function is_result;
        input [7:0] addr;
        begin
            case (addr)
                `AWCR_ADDR_PROGRESS: is_result = 1'b1;
                `AWCR_ADDR_SUM_LOW: is_result = 1'b1;
                `AWCR_ADDR_SUM_HIGH: is_result = 1'b1;
                default: is_result = 1'b0;
            endcase
        end
    endfunction

    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    wire wr_summing;
    wire wr_alert;
    wire wr_window;
    wire wr_upper_low;
    wire wr_upper_high;
    wire wr_lower_low;
    wire wr_lower_high;

    assign wr_summing =
        wr_hit(reg_addr_in, `AWCR_ADDR_SUMMING_EN, reg_wr_in);
    assign wr_alert =
        wr_hit(reg_addr_in, `AWCR_ADDR_ALERT_EN, reg_wr_in);
    assign wr_window =
        wr_hit(reg_addr_in, `AWCR_ADDR_WINDOW_EN, reg_wr_in);
    assign wr_upper_low =
        wr_hit(reg_addr_in, `AWCR_ADDR_UPPER_LOW, reg_wr_in);
    assign wr_upper_high =
        wr_hit(reg_addr_in, `AWCR_ADDR_UPPER_HIGH, reg_wr_in);
    assign wr_lower_low =
        wr_hit(reg_addr_in, `AWCR_ADDR_LOWER_LOW, reg_wr_in);
    assign wr_lower_high =
        wr_hit(reg_addr_in, `AWCR_ADDR_LOWER_HIGH, reg_wr_in);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    reg [3:0] summing_on;
    reg window_compare_on;
    reg chan0_alert_on;
    reg chan1_alert_on;
    reg [7:0] chan0_upper_limit_byte;
    reg [3:0] chan0_upper_limit_nibble;
    reg [7:0] chan0_lower_limit_byte;
    reg [3:0] chan0_lower_limit_nibble;

    wire soft_reset;
    wire results_clear;

    // general call and device reset restore the control registers and clear the results
    assign soft_reset = general_call_reset_in || device_reset_in;
    assign results_clear = soft_reset || sequence_go_in;

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            summing_on <= `AWCR_RST_NIBBLE;
            window_compare_on <= `AWCR_RST_BIT;
            chan0_alert_on <= `AWCR_RST_BIT;
            chan1_alert_on <= `AWCR_RST_BIT;
            chan0_upper_limit_byte <= `AWCR_RST_BYTE;
            chan0_upper_limit_nibble <= `AWCR_RST_NIBBLE;
            chan0_lower_limit_byte <= `AWCR_RST_BYTE;
            chan0_lower_limit_nibble <= `AWCR_RST_NIBBLE;
        end else if (soft_reset) begin
            summing_on <= `AWCR_RST_NIBBLE;
            window_compare_on <= `AWCR_RST_BIT;
            chan0_alert_on <= `AWCR_RST_BIT;
            chan1_alert_on <= `AWCR_RST_BIT;
            chan0_upper_limit_byte <= `AWCR_RST_BYTE;
            chan0_upper_limit_nibble <= `AWCR_RST_NIBBLE;
            chan0_lower_limit_byte <= `AWCR_RST_BYTE;
            chan0_lower_limit_nibble <= `AWCR_RST_NIBBLE;
        end else begin
            if (wr_summing) begin
                summing_on <= reg_wdata_in[3:0];
            end
            if (wr_window) begin
                // only bit 0 is stored; bits 7-1 have no flops
                window_compare_on <= reg_wdata_in[`AWCR_BIT_WINDOW_ON];
            end
            if (wr_alert) begin
                chan0_alert_on <= reg_wdata_in[`AWCR_BIT_CHAN0_ALERT];
                chan1_alert_on <= reg_wdata_in[`AWCR_BIT_CHAN1_ALERT];
            end
            if (wr_upper_low) begin
                chan0_upper_limit_byte <= reg_wdata_in;
            end
            if (wr_upper_high) begin
                chan0_upper_limit_nibble <=
                    reg_wdata_in[`AWCR_NIBBLE_MSB:0];
            end
            if (wr_lower_low) begin
                chan0_lower_limit_byte <= reg_wdata_in;
            end
            if (wr_lower_high) begin
                chan0_lower_limit_nibble <=
                    reg_wdata_in[`AWCR_NIBBLE_MSB:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // datapath controls
    // ----------------------------------------------------------------

    // reserved codes leave the accumulator idle, same as off
    assign summing_active_out =
        (summing_on == `AWCR_SUMMING_CODE_ON);
    assign window_compare_on_out = window_compare_on;
    assign chan0_alert_on_out = chan0_alert_on;
    assign chan1_alert_on_out = chan1_alert_on;
    assign chan0_upper_limit_out =
        {chan0_upper_limit_nibble, chan0_upper_limit_byte};
    assign chan0_lower_limit_out =
        {chan0_lower_limit_nibble, chan0_lower_limit_byte};

    // ----------------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------------
    wire [15:0] sum;
    wire [3:0] count;

    awcr_accum awcr_accum_i (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(results_clear),
        .run_in(summing_active_out),
        .conv_done_in(conv_done_in),
        .conv_chan_in(conv_chan_in),
        .conv_data_in(conv_data_in),
        .sum_out(sum),
        .count_out(count)
    );

    assign chan1_sum_out = sum;
    assign accumulations_done_out = count;

    // ----------------------------------------------------------------
    // window comparator, channel 0
    // ----------------------------------------------------------------
    wire chan0_above;
    wire chan0_below;

    awcr_window awcr_window_i (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .active_in(window_compare_on),
        .upper_limit_in(chan0_upper_limit_out),
        .lower_limit_in(chan0_lower_limit_out),
        .conv_done_in(conv_done_in),
        .conv_chan_in(conv_chan_in),
        .conv_data_in(conv_data_in),
        .above_out(chan0_above),
        .below_out(chan0_below)
    );

    // ----------------------------------------------------------------
    // alert gating
    // ----------------------------------------------------------------
    wire next_chan0_alert;
    wire next_chan1_alert;

    assign next_chan0_alert = window_compare_on && chan0_alert_on &&
                              (chan0_above || chan0_below);
    assign next_chan1_alert = window_compare_on && chan1_alert_on &&
                              (chan1_above_in || chan1_below_in);

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chan0_alert_out <= `AWCR_RST_BIT;
            chan1_alert_out <= `AWCR_RST_BIT;
        end else begin
            chan0_alert_out <= next_chan0_alert;
            chan1_alert_out <= next_chan1_alert;
        end
    end

    // ----------------------------------------------------------------
    // read-only words
    // ----------------------------------------------------------------
    wire [7:0] progress_word;
    wire [7:0] sum_low_word;
    wire [7:0] sum_high_word;

    // upper status nibble has no flops behind it
    assign progress_word = {4'h0, count};
    assign sum_low_word = sum[7:0];
    assign sum_high_word = sum[15:8];

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    reg [7:0] next_rdata;

    // reads are pure muxing: only reg_rdata_out changes on a read
    always @* begin
        next_rdata = `AWCR_READ_NONE;
        case (reg_addr_in)
            `AWCR_ADDR_PROGRESS: begin
                next_rdata = progress_word;
            end
            `AWCR_ADDR_SUM_LOW: begin
                next_rdata = sum_low_word;
            end
            `AWCR_ADDR_SUM_HIGH: begin
                next_rdata = sum_high_word;
            end
            `AWCR_ADDR_SUMMING_EN: begin
                next_rdata = {4'h0, summing_on};
            end
            `AWCR_ADDR_ALERT_EN: begin
                next_rdata = {6'h00, chan1_alert_on, chan0_alert_on};
            end
            `AWCR_ADDR_WINDOW_EN: begin
                next_rdata = {7'h00, window_compare_on};
            end
            `AWCR_ADDR_UPPER_LOW: begin
                next_rdata = chan0_upper_limit_byte;
            end
            `AWCR_ADDR_UPPER_HIGH: begin
                next_rdata = {4'h0, chan0_upper_limit_nibble};
            end
            `AWCR_ADDR_LOWER_LOW: begin
                next_rdata = chan0_lower_limit_byte;
            end
            `AWCR_ADDR_LOWER_HIGH: begin
                next_rdata = {4'h0, chan0_lower_limit_nibble};
            end
            default: begin
                next_rdata = `AWCR_READ_NONE;
            end
        endcase
    end

    // data held between reads so the serial engine can shift it out
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `AWCR_RST_BYTE;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // hit flag
    // ----------------------------------------------------------------
    wire write_target;
    wire read_target;

    // result registers are absent from the write decode, so writes drop
    assign write_target = is_writable(reg_addr_in);
    assign read_target = is_result(reg_addr_in) && !reg_wr_in;
    assign reg_hit_out = write_target || read_target;

endmodule
`default_nettype wire

/* File: awcr_defines.vh */
`ifndef AWCR_DEFINES_VH
`define AWCR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AWCR_ADDR_PROGRESS 8'h02
`define AWCR_ADDR_SUM_LOW 8'h0A
`define AWCR_ADDR_SUM_HIGH 8'h0B
`define AWCR_ADDR_SUMMING_EN 8'h30
`define AWCR_ADDR_ALERT_EN 8'h34
`define AWCR_ADDR_WINDOW_EN 8'h37
`define AWCR_ADDR_UPPER_LOW 8'h38
`define AWCR_ADDR_UPPER_HIGH 8'h39
`define AWCR_ADDR_LOWER_LOW 8'h3A
`define AWCR_ADDR_LOWER_HIGH 8'h3B

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AWCR_BIT_WINDOW_ON 0
`define AWCR_BIT_CHAN0_ALERT 0
`define AWCR_BIT_CHAN1_ALERT 1
`define AWCR_NIBBLE_MSB 3
`define AWCR_CHAN_ONE 1'h1

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define AWCR_RST_BYTE 8'h00
`define AWCR_RST_NIBBLE 4'h0
`define AWCR_RST_BIT 1'h0
`define AWCR_RST_SUM 16'h0000
`define AWCR_RST_LIMIT 12'h000
`define AWCR_SUMMING_CODE_ON 4'hF
`define AWCR_SUMMING_CODE_OFF 4'h0
`define AWCR_COUNT_MAX 4'hF
`define AWCR_READ_NONE 8'h00

`endif

/* File: awcr_accum.v */
`timescale 1ns/1ps
`default_nettype none
`include "awcr_defines.vh"

module awcr_accum (
    // clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // control
    input wire clear_in,
    input wire run_in,
    // conversion results
    input wire conv_done_in,
    input wire conv_chan_in,
    input wire [11:0] conv_data_in,
    // results
    output reg [15:0] sum_out,
    output reg [3:0] count_out
);

    wire take;

    assign take = run_in && conv_done_in && (conv_chan_in == `AWCR_CHAN_ONE);

    // clear beats a conversion in the same cycle: a new sequence starts empty
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sum_out <= `AWCR_RST_SUM;
            count_out <= `AWCR_RST_NIBBLE;
        end else if (clear_in) begin
            sum_out <= `AWCR_RST_SUM;
            count_out <= `AWCR_RST_NIBBLE;
        end else if (take) begin
            sum_out <= sum_out + {4'h0, conv_data_in};
            // count sticks at its top so it never reads as a fresh start
            if (count_out != `AWCR_COUNT_MAX) begin
                count_out <= count_out + 4'h1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: awcr_window.v */
`timescale 1ns/1ps
`default_nettype none
`include "awcr_defines.vh"

module awcr_window (
    // clock and reset
    input wire clock_in,
    input wire sys_rst_in,
    // control
    input wire active_in,
    input wire [11:0] upper_limit_in,
    input wire [11:0] lower_limit_in,
    // conversion results
    input wire conv_done_in,
    input wire conv_chan_in,
    input wire [11:0] conv_data_in,
    // events
    output reg above_out,
    output reg below_out
);

    wire chan0_done;

    assign chan0_done = active_in && conv_done_in &&
                        (conv_chan_in != `AWCR_CHAN_ONE);

    // result held until next channel-0 conversion; dropped when disabled
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            above_out <= `AWCR_RST_BIT;
            below_out <= `AWCR_RST_BIT;
        end else if (!active_in) begin
            above_out <= `AWCR_RST_BIT;
            below_out <= `AWCR_RST_BIT;
        end else if (chan0_done) begin
            above_out <= (conv_data_in > upper_limit_in);
            below_out <= (conv_data_in < lower_limit_in);
        end
    end

endmodule
`default_nettype wire

/* File: awcr_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module awcr_regs_chk (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // register access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // clearing events and conversions
    input wire logic general_call_reset_in,
    input wire logic device_reset_in,
    input wire logic sequence_go_in,
    input wire logic conv_done_in,
    input wire logic conv_chan_in,
    input wire logic [11:0] conv_data_in,
    // controls and results
    input wire logic summing_active_out,
    input wire logic window_compare_on_out,
    input wire logic chan0_alert_on_out,
    input wire logic chan1_alert_on_out,
    input wire logic [11:0] chan0_upper_limit_out,
    input wire logic [11:0] chan0_lower_limit_out,
    input wire logic [15:0] chan1_sum_out,
    input wire logic [3:0] accumulations_done_out,
    input wire logic chan0_alert_out,
    input wire logic chan1_alert_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a clearing pulse wins over a write in the same cycle; a read still loads the pre-clear data
    wire logic clr = general_call_reset_in | device_reset_in;
    wire logic quiet = !clr && !sequence_go_in;
    wire logic wr = reg_wr_in && !clr;
    wire logic rd = reg_rd_in && !clr;
    wire logic ch1 = conv_done_in && conv_chan_in && quiet;
    wire logic [3:0] wd_nib = reg_wdata_in[3:0];
    wire logic [1:0] wd_two = reg_wdata_in[1:0];
    wire logic wd_bit = reg_wdata_in[0];
    wire logic [7:0] sum_lo = chan1_sum_out[7:0];
    wire logic [7:0] sum_hi = chan1_sum_out[15:8];
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_upper_byte: assert property (
        wr && reg_addr_in == 8'h38 |=>
        chan0_upper_limit_out[7:0] == $past(reg_wdata_in))
        else $error("upper limit byte not taken");
    a_upper_nibble: assert property (
        wr && reg_addr_in == 8'h39 |=>
        chan0_upper_limit_out[11:8] == $past(wd_nib))
        else $error("upper limit nibble not taken");
    a_lower_byte: assert property (
        wr && reg_addr_in == 8'h3A |=>
        chan0_lower_limit_out[7:0] == $past(reg_wdata_in))
        else $error("lower limit byte not taken");
    a_lower_nibble: assert property (
        wr && reg_addr_in == 8'h3B |=>
        chan0_lower_limit_out[11:8] == $past(wd_nib))
        else $error("lower limit nibble not taken");
    a_window_bit: assert property (
        wr && reg_addr_in == 8'h37 |=> window_compare_on_out == $past(wd_bit))
        else $error("window enable not taken");
    a_alert_bits: assert property (
        wr && reg_addr_in == 8'h34 |=>
        {chan1_alert_on_out, chan0_alert_on_out} == $past(wd_two))
        else $error("alert enables not taken");
    a_sum_adds: assert property (
        ch1 && summing_active_out |=>
        chan1_sum_out == $past(chan1_sum_out) + $past(conv_data_in))
        else $error("sum did not add result");
    a_sum_idle: assert property (
        ch1 && !summing_active_out |=>
        $stable(chan1_sum_out) && $stable(accumulations_done_out))
        else $error("sum moved while disabled");
    a_results_clear: assert property (
        !quiet |=> chan1_sum_out == 16'h0000 && accumulations_done_out == 4'h0)
        else $error("results not cleared");
    a_status_read: assert property (
        rd && reg_addr_in == 8'h02 |=>
        reg_rdata_out == {4'h0, $past(accumulations_done_out)})
        else $error("status read wrong");
    a_sum_low_read: assert property (
        rd && reg_addr_in == 8'h0A |=> reg_rdata_out == $past(sum_lo))
        else $error("sum low read wrong");
    a_sum_high_read: assert property (
        rd && reg_addr_in == 8'h0B |=> reg_rdata_out == $past(sum_hi))
        else $error("sum high read wrong");
    a_window_reserved: assert property (
        rd && reg_addr_in == 8'h37 |=> reg_rdata_out[7:1] == 7'h00)
        else $error("window reserved bits not zero");
    a_result_write: assert property (
        wr && quiet && !conv_done_in && reg_addr_in == 8'h0A |=>
        $stable(chan1_sum_out))
        else $error("write changed the sum");
    a_chan0_gate: assert property (
        !chan0_alert_on_out [*2] |-> !chan0_alert_out)
        else $error("channel 0 alert while disabled");
    a_chan1_gate: assert property (
        !chan1_alert_on_out [*2] |-> !chan1_alert_out)
        else $error("channel 1 alert while disabled");
endmodule
bind awcr_regs awcr_regs_chk awcr_regs_chk_i (.*);
`default_nettype wire

/* File: awcr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module awcr_host (
    // clock
    input wire logic clock_in,
    // register access
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out = 8'h00,
    output logic reg_wr_out = 1'b0,
    output logic [7:0] reg_wdata_out = 8'h00,
    output logic reg_rd_out = 1'b0
);
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clock_in);
        reg_wr_out <= 1'b0;
        // data is not held once the strobe drops
        reg_wdata_out <= ~d;
        #1;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clock_in);
        reg_rd_out <= 1'b0;
        #1;
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

/* File: awcr_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t got %h expected %h", $time, a, b); end end
module awcr_regs_tb_top;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic gcr = 1'b0, drs = 1'b0, seq_go = 1'b0, above = 1'b0;
    logic below = 1'b0;
    logic cv_done = 1'b0, cv_chan = 1'b0;
    logic [11:0] cv_data = 12'h000;
    wire logic [7:0] addr, wdata, rdata;
    wire logic wr, rd, hit, sum_on, win_on, en0, en1, al0, al1;
    wire logic [11:0] up_lim, lo_lim;
    wire logic [15:0] sum;
    wire logic [3:0] cnt;
    int fails = 0;
    int n_tests = 0;
    always #50 clock_in = ~clock_in;
    awcr_host awcr_host_i (.clock_in(clock_in), .reg_rdata_in(rdata),
        .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
        .reg_rd_out(rd));
    awcr_regs awcr_regs_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .general_call_reset_in(gcr), .device_reset_in(drs),
        .sequence_go_in(seq_go), .conv_done_in(cv_done),
        .conv_chan_in(cv_chan), .conv_data_in(cv_data),
        .chan1_above_in(above), .chan1_below_in(below),
        .summing_active_out(sum_on), .window_compare_on_out(win_on),
        .chan0_alert_on_out(en0), .chan1_alert_on_out(en1),
        .chan0_upper_limit_out(up_lim), .chan0_lower_limit_out(lo_lim),
        .chan1_sum_out(sum), .accumulations_done_out(cnt),
        .chan0_alert_out(al0), .chan1_alert_out(al1));
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        awcr_host_i.get(a, v);
        `CHK(v, e)
    endtask
    task automatic conv(input logic c, input logic [11:0] d);
        @(posedge clock_in);
        cv_done <= 1'b1;
        cv_chan <= c;
        cv_data <= d;
        @(posedge clock_in);
        cv_done <= 1'b0;
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clock_in);
        {gcr, drs, seq_go} <= 3'b100 >> k;
        @(posedge clock_in);
        {gcr, drs, seq_go} <= 3'b000;
        #1;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic t_reset;
        logic [7:0] a [10] = '{8'h02, 8'h0A, 8'h0B, 8'h30, 8'h34, 8'h37,
            8'h38, 8'h39, 8'h3A, 8'h3B};
        foreach (a[i]) rdchk(a[i], 8'h00);
        rdchk(8'h55, 8'h00);
        `CHK(hit, 1'b0)
        $display("reset values done");
    endtask
    task automatic t_limits;
        awcr_host_i.put(8'h38, 8'hA5);
        awcr_host_i.put(8'h39, 8'hFF);
        awcr_host_i.put(8'h3A, 8'h3C);
        awcr_host_i.put(8'h3B, 8'hF1);
        `CHK(up_lim, 12'hFA5)
        `CHK(lo_lim, 12'h13C)
        rdchk(8'h39, 8'h0F);
        rdchk(8'h3B, 8'h01);
        rdchk(8'h3A, 8'h3C);
        `CHK(hit, 1'b1)
        $display("limits done");
    endtask
    task automatic t_enables;
        awcr_host_i.put(8'h37, 8'hFF);
        `CHK(win_on, 1'b1)
        rdchk(8'h37, 8'h01);
        awcr_host_i.put(8'h34, 8'hFE);
        `CHK({en1, en0}, 2'b10)
        rdchk(8'h34, 8'h02);
        $display("enables done");
    endtask
    task automatic t_accum;
        awcr_host_i.put(8'h30, 8'h07);
        conv(1'b1, 12'h123);
        `CHK(sum_on, 1'b0)
        `CHK(sum, 16'h0000)
        awcr_host_i.put(8'h30, 8'h0F);
        `CHK(sum_on, 1'b1)
        repeat (17) conv(1'b1, 12'hFFF);
        conv(1'b0, 12'h555);
        rdchk(8'h0A, 8'hEF);
        rdchk(8'h0B, 8'h0F);
        rdchk(8'h02, 8'h0F);
        awcr_host_i.put(8'h0A, 8'h00);
        awcr_host_i.put(8'h02, 8'hF0);
        rdchk(8'h0A, 8'hEF);
        rdchk(8'h02, 8'h0F);
        pulse(2);
        `CHK({sum, cnt}, 20'h00000)
        `CHK(up_lim, 12'hFA5)
        conv(1'b1, 12'h001);
        rdchk(8'h02, 8'h01);
        $display("accumulator done");
    endtask
    task automatic t_alert;
        conv(1'b0, 12'hFFF);
        settle(1);
        `CHK(al0, 1'b0)
        awcr_host_i.put(8'h34, 8'h03);
        settle(2);
        `CHK(al0, 1'b1)
        @(posedge clock_in);
        above <= 1'b1;
        settle(3);
        `CHK(al1, 1'b1)
        @(posedge clock_in);
        above <= 1'b0;
        below <= 1'b1;
        settle(2);
        `CHK(al1, 1'b1)
        awcr_host_i.put(8'h34, 8'h01);
        settle(2);
        `CHK({al1, al0}, 2'b01)
        conv(1'b0, 12'h010);
        settle(1);
        `CHK(al0, 1'b1)
        awcr_host_i.put(8'h37, 8'h00);
        settle(3);
        `CHK(al0, 1'b0)
        for (int k = 0; k < 2; k++) begin
            conv(1'b1, 12'h0AB);
            pulse(k);
            `CHK({sum, cnt, up_lim}, 32'h00000000)
            awcr_host_i.put(8'h39, 8'h02);
        end
        $display("alerts and clears done");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_limits;
        t_enables;
        t_accum;
        t_alert;
        final_report;
    end
    // the whole sequence needs under two hundred cycles
    initial begin
        #(5000 * 100);
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
